//--- rtl/xpc_host.sv
// Purpose: Host end: drives serial frames, parallel words, latch
// Assumes: Strobe made by dividing sys_clk
// Notes: One request at a time; ready while idle
`timescale 1ns/1ps
`include "xpc_defines.svh"
module xpc_host #(
	parameter int HALF_CYC = `XPC_STROBE_HALF_CYC
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Link to device
	xpc_if.host link,
	// Mode settings
	input wire logic cfg_serial,
	input wire logic cfg_edge,
	// Requests
	input wire logic req_valid,
	output logic req_ready,
	input wire xpc_pkg::xpc_req_t req_kind,
	input wire logic [31:0] req_frame,
	input wire logic [2:0] req_addr,
	input wire logic [3:0] req_code,
	// Answers
	output logic done,
	output logic err
);
	if (HALF_CYC < 1 || HALF_CYC > 255)
	begin : g_bad_half
		$error("xpc_host: HALF_CYC out of range");
	end

	xpc_pkg::xpc_state_t state_reg; // Sequencer state
	logic [7:0] tick_reg; // Cycles left in phase
	logic [5:0] bits_reg; // Serial bits left
	logic [31:0] shift_reg; // Outgoing frame, sent from top
	logic frame_bad; // Request frame carries an illegal code
	logic last_tick; // Phase ends now

	assign req_ready = (state_reg == xpc_pkg::XPC_ST_IDLE);
	assign last_tick = (tick_reg == 8'h00);

	// Refuse frames with codes above 1010
	always_comb
	begin
		frame_bad = 1'b0;
		for (int i = 0; i < 8; i++)
			frame_bad = frame_bad | (req_frame[4*i +: 4] > `XPC_CODE_OFF);
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			state_reg <= xpc_pkg::XPC_ST_IDLE;
			tick_reg <= 8'h00;
			bits_reg <= 6'h00;
			shift_reg <= 32'h0000_0000;
		end
		else
		begin
			unique case (state_reg)
				xpc_pkg::XPC_ST_IDLE:
				begin
					tick_reg <= 8'(HALF_CYC - 1);
					// Latch after words applies them together
					if (req_valid && req_kind == xpc_pkg::XPC_REQ_LATCH)
						state_reg <= xpc_pkg::XPC_ST_LATCH_LO;
					else if (req_valid && req_kind == xpc_pkg::XPC_REQ_WORD && !cfg_serial)
					begin
						bits_reg <= 6'h01;
						shift_reg <= {req_code, 28'h000_0000};
						state_reg <= xpc_pkg::XPC_ST_SETUP;
					end
					else if (req_valid && req_kind == xpc_pkg::XPC_REQ_FRAME && cfg_serial
						&& !frame_bad)
					begin
						bits_reg <= 6'h20;
						shift_reg <= req_frame;
						state_reg <= xpc_pkg::XPC_ST_SETUP;
					end
				end
				xpc_pkg::XPC_ST_SETUP:
				begin
					tick_reg <= last_tick ? 8'(HALF_CYC - 1) : tick_reg - 8'h01;
					if (last_tick)
						state_reg <= xpc_pkg::XPC_ST_STROBE;
				end
				xpc_pkg::XPC_ST_STROBE:
				begin
					tick_reg <= last_tick ? 8'(HALF_CYC - 1) : tick_reg - 8'h01;
					if (last_tick)
					begin
						// Next bit, most significant first
						shift_reg <= {shift_reg[30:0], 1'b0};
						bits_reg <= bits_reg - 6'h01;
						state_reg <= (bits_reg == 6'h01) ? xpc_pkg::XPC_ST_IDLE :
							xpc_pkg::XPC_ST_SETUP;
					end
				end
				xpc_pkg::XPC_ST_LATCH_LO:
				begin
					tick_reg <= last_tick ? 8'(HALF_CYC - 1) : tick_reg - 8'h01;
					if (last_tick)
						state_reg <= xpc_pkg::XPC_ST_LATCH_HI;
				end
				xpc_pkg::XPC_ST_LATCH_HI:
				begin
					tick_reg <= last_tick ? 8'(HALF_CYC - 1) : tick_reg - 8'h01;
					if (last_tick)
						state_reg <= xpc_pkg::XPC_ST_IDLE;
				end
				// Three spare codes of the state word; recover to idle
				default:
					state_reg <= xpc_pkg::XPC_ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Answers
	// ****************************************
	// Done marks the end of each transfer; err marks a refused request
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			done <= 1'b0;
			err <= 1'b0;
		end
		else
		begin
			done <= last_tick && ((state_reg == xpc_pkg::XPC_ST_STROBE && bits_reg == 6'h01)
				|| state_reg == xpc_pkg::XPC_ST_LATCH_HI);
			err <= req_ready && req_valid && req_kind != xpc_pkg::XPC_REQ_LATCH &&
				(cfg_serial != (req_kind == xpc_pkg::XPC_REQ_FRAME) ||
				(req_kind == xpc_pkg::XPC_REQ_FRAME && frame_bad));
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	// All pins from flops; latch idles high so a pulse ends on a rise
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			link.wr <= 1'b0;
			link.latch <= 1'b1;
			link.ce <= 1'b0;
			link.ce_n <= 1'b1;
			link.interface_style_select <= 1'b0;
			link.edge_select <= 1'b0;
			link.buffer_select <= 3'h0;
			link.host_code <= 4'h0;
			link.host_d1_oe_n <= 1'b0;
		end
		else
		begin
			link.wr <= (state_reg == xpc_pkg::XPC_ST_STROBE);
			link.latch <= (state_reg != xpc_pkg::XPC_ST_LATCH_LO);
			// Enables asserted only while a write is under way
			link.ce <= (state_reg == xpc_pkg::XPC_ST_SETUP || state_reg == xpc_pkg::XPC_ST_STROBE);
			link.ce_n <= !(state_reg == xpc_pkg::XPC_ST_SETUP ||
				state_reg == xpc_pkg::XPC_ST_STROBE);
			if (req_ready)
			begin
				link.interface_style_select <= cfg_serial;
				link.edge_select <= cfg_edge;
				link.host_d1_oe_n <= cfg_serial;
			end
			if (req_ready && req_valid && req_kind == xpc_pkg::XPC_REQ_WORD)
				link.buffer_select <= req_addr;
			// Serial bit rides on code bit zero; parallel uses all four
			link.host_code <= cfg_serial ? {3'h0, shift_reg[31]} : shift_reg[31:28];
		end
	end
endmodule // xpc_host

//--- include/xpc_defines.svh
// Purpose: Shared constants of the crosspoint control link
// Assumes: One 4-bit code per output, eight outputs
// Notes: Included by both ends; definitions only
//
// What this block does
// - Serial mode loads all first-rank entries
// - Frame is 32 bits, output zero first
// - Host sends serial codes up to 1010
// - Latch copies full first rank to second
// - Codes 0000-0111 select input channel
// - Code 1000 grounds input, enable kept
// - Serial code 1001 enables buffer, grounds input
// - All buffers disabled after reset
// - Serial code 1010 disables buffer, stored as 1010
// - Serial codes above 1010 inhibit second-rank load
// - Parallel word captured on strobe rise
// - Latch updates all eight outputs together
// - Parallel channel or ground word changes exactly one entry
// - Host writes words, then one latch
// - Top code bit selects control or channel
// - Strobe acts only on rising edge
// - Edge select: rise loads, else low follows
// - Strobe gated by both chip enables
// - Each serial strobe shifts one bit
`ifndef XPC_DEFINES_SVH
`define XPC_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define XPC_NUM_OUT 8
`define XPC_CODE_W 4
`define XPC_ADDR_W 3
`define XPC_FRAME_W 32

// ****************************************
// Command codes
// ****************************************
`define XPC_CODE_GND 4'h8
`define XPC_CODE_ON_GND 4'h9
`define XPC_CODE_OFF 4'hA
`define XPC_CODE_OFF_ONE 4'hB
`define XPC_CODE_ON_ONE 4'hC
`define XPC_CODE_OFF_ALL 4'hD
`define XPC_CODE_ON_ALL 4'hE
`define XPC_CODE_SOFT_LATCH 4'hF
`define XPC_CODE_TOP_BIT 3

// ****************************************
// Reset values and timing
// ****************************************
`define XPC_SECOND_RST 32'h0000_0000
`define XPC_BUF_ON_RST 8'h00
`define XPC_CLK_NS 4
`define XPC_STROBE_HALF_NS 32
`define XPC_STROBE_HALF_CYC ((`XPC_STROBE_HALF_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS)

`endif

//--- include/xpc_pkg.sv
// Purpose: Types shared by the crosspoint link ends
// Assumes: Nothing beyond the defines header
// Notes: Types only; numbers live in the defines header
package xpc_pkg;

	// ****************************************
	// Host request kinds
	// ****************************************
	typedef enum logic [1:0]
	{
		XPC_REQ_FRAME,
		XPC_REQ_WORD,
		XPC_REQ_LATCH
	} xpc_req_t;

	// Host sequencer states
	typedef enum logic [2:0]
	{
		XPC_ST_IDLE,
		XPC_ST_SETUP,
		XPC_ST_STROBE,
		XPC_ST_LATCH_LO,
		XPC_ST_LATCH_HI
	} xpc_state_t;

endpackage

//--- include/xpc_if.sv
// Purpose: Pin-level link between host and crosspoint control
// Assumes: Code bit one is shared; shift output in serial mode
// Notes: Resolves the shared pin from both output enables
`timescale 1ns/1ps
interface xpc_if;
	logic wr; // Write strobe, also shift clock
	logic latch; // Second-rank load
	logic ce; // Active-high chip enable
	logic ce_n; // Active-low chip enable
	logic interface_style_select; // High serial, low parallel
	logic edge_select; // High edge latch, low level latch
	logic [2:0] buffer_select; // Output address
	logic [3:0] host_code; // Code bits as driven by host
	logic host_d1_oe_n; // Host drives bit one when low
	logic shift_out; // Device serial output on bit one
	logic shift_out_oe_n; // Device drives bit one when low
	logic [3:0] command_code; // Resolved code lines

	// Bit one: device wins in serial mode, weak low when floating
	assign command_code[3:2] = host_code[3:2];
	assign command_code[0] = host_code[0];
	assign command_code[1] = !shift_out_oe_n ? shift_out :
		(!host_d1_oe_n ? host_code[1] : 1'b0);

	modport dev
	(
		input wr, latch, ce, ce_n, interface_style_select, edge_select,
		input buffer_select, command_code,
		output shift_out, shift_out_oe_n
	);

	modport host
	(
		output wr, latch, ce, ce_n, interface_style_select, edge_select,
		output buffer_select, host_code, host_d1_oe_n,
		input command_code
	);
endinterface

//--- rtl/xpc_sync.sv
// Purpose: Two-flop synchroniser for link pins
// Assumes: Inputs are asynchronous to sys_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module xpc_sync #(
	parameter int WIDTH = 1
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Data
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage1_reg; // Metastability catcher, not read elsewhere

	// ****************************************
	// Two-stage capture
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			stage1_reg <= '0;
			pin_sync <= '0;
		end
		else
		begin
			stage1_reg <= pin_in;
			pin_sync <= stage1_reg;
		end
	end
endmodule // xpc_sync

//--- rtl/xpc_device.sv
// Purpose: Crosspoint control end: two-rank switch register file
// Assumes: Host pins asynchronous; sampled on sys_clk
// Notes: Outputs give channel, ground and buffer enable per output
`timescale 1ns/1ps
`include "xpc_defines.svh"
module xpc_device #(
	parameter int NUM_OUT = `XPC_NUM_OUT
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Link to host
	xpc_if.dev link,
	// Switch state
	output logic [NUM_OUT*3-1:0] conn_chan,
	output logic [NUM_OUT-1:0] conn_gnd,
	output logic [NUM_OUT-1:0] buf_on
);
	localparam int CW = `XPC_CODE_W;
	localparam int FW = NUM_OUT * CW;

	// Frame layout is fixed by the 32-bit serial format
	if (NUM_OUT != `XPC_NUM_OUT || FW != `XPC_FRAME_W)
	begin : g_bad_size
		$error("xpc_device: NUM_OUT must be 8");
	end

	// ****************************************
	// Helpers
	// ****************************************
	// Codes above 1010 are illegal in a serial frame
	function automatic logic code_bad(input logic [3:0] c);
		code_bad = (c > `XPC_CODE_OFF);
	endfunction

	// Nibble of output i within the frame, output zero on top
	function automatic logic [3:0] nib(input logic [FW-1:0] v, input int i);
		nib = v[FW-1-CW*i -: CW];
	endfunction

	// ****************************************
	// Pin synchronisation
	// ****************************************
	logic [12:0] pins_raw; // All host pins gathered
	logic [12:0] pins_s; // Synchronised copy
	logic wr_s; // Strobe level
	logic latch_s; // Latch level
	logic ce_s; // High enable
	logic ce_n_s; // Low enable
	logic serial_s; // Serial mode
	logic edge_s; // Edge latch mode
	logic [2:0] addr_s; // Buffer select
	logic [3:0] code_s; // Command code

	assign pins_raw = {link.wr, link.latch, link.ce, link.ce_n, link.interface_style_select,
		link.edge_select, link.buffer_select, link.command_code};
	assign {wr_s, latch_s, ce_s, ce_n_s, serial_s, edge_s, addr_s, code_s} = pins_s;

	xpc_sync #(.WIDTH(13)) u_sync
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin_in(pins_raw),
		.pin_sync(pins_s)
	);

	// ****************************************
	// Edge detection
	// ****************************************
	logic wr_gated; // Strobe qualified by enables
	logic wr_prev_reg; // Previous qualified strobe
	logic latch_prev_reg; // Previous latch level
	logic wr_rise; // Qualified strobe rising edge
	logic latch_rise; // Latch rising edge

	assign wr_gated = wr_s & ce_s & ~ce_n_s;
	assign wr_rise = wr_gated & ~wr_prev_reg;
	assign latch_rise = latch_s & ~latch_prev_reg;

	// Remember last levels for edge finding
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			wr_prev_reg <= 1'b0;
			latch_prev_reg <= 1'b0;
		end
		else
		begin
			wr_prev_reg <= wr_gated;
			latch_prev_reg <= latch_s;
		end
	end

	// ****************************************
	// First rank
	// ****************************************
	logic [FW-1:0] first_reg; // Pending codes, output zero in top nibble
	logic par_store; // Parallel word that lands in first rank

	// Channel codes and ground code are stored; 1001 and 1010 ignored in parallel
	assign par_store = !code_s[`XPC_CODE_TOP_BIT] || code_s == `XPC_CODE_GND;

	// Shift in serial mode, single-entry write in parallel mode
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			first_reg <= '0;
		else if (wr_rise && serial_s)
			first_reg <= {first_reg[FW-2:0], code_s[0]};
		else if (wr_rise && par_store)
		begin
			for (int i = 0; i < NUM_OUT; i++)
			begin
				// Only the addressed entry moves
				if (addr_s == i[2:0])
					first_reg[FW-1-CW*i -: CW] <= code_s;
			end
		end
	end

	// Bit leaving the top of the chain feeds the next device
	assign link.shift_out = first_reg[FW-1];
	assign link.shift_out_oe_n = ~serial_s;

	// ****************************************
	// Load decision
	// ****************************************
	logic any_bad; // Serial frame holds an illegal code
	logic pin_load; // Latch pin asks for a load
	logic par_ctrl; // Parallel control word strobed
	logic soft_load; // Parallel codes that also load
	logic load; // Copy first rank to second rank

	// Scan every entry for illegal serial codes
	always_comb
	begin
		any_bad = 1'b0;
		for (int i = 0; i < NUM_OUT; i++)
			any_bad = any_bad | code_bad(nib(first_reg, i));
	end

	assign pin_load = edge_s ? latch_rise : ~latch_s;
	assign par_ctrl = wr_rise && !serial_s && code_s[`XPC_CODE_TOP_BIT];
	// 1011..1110 load as they act; 1111 loads only with latch high
	assign soft_load = par_ctrl && code_s > `XPC_CODE_OFF &&
		(code_s != `XPC_CODE_SOFT_LATCH || latch_s);
	// Illegal serial codes inhibit the load entirely
	assign load = (pin_load && !(serial_s && any_bad)) || soft_load;

	// ****************************************
	// Second rank
	// ****************************************
	logic [FW-1:0] second_reg; // Applied codes

	// All entries copy in one cycle so outputs switch together
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			second_reg <= `XPC_SECOND_RST;
		else if (load)
			second_reg <= first_reg;
	end

	// ****************************************
	// Buffer enables
	// ****************************************
	// Loaded codes first, then direct parallel controls override
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			buf_on <= `XPC_BUF_ON_RST;
		else
		begin
			for (int i = 0; i < NUM_OUT; i++)
			begin
				if (load && nib(first_reg, i) == `XPC_CODE_ON_GND)
					buf_on[i] <= 1'b1;
				else if (load && nib(first_reg, i) == `XPC_CODE_OFF)
					buf_on[i] <= 1'b0;
				// Channel and ground codes keep the enable
				if (par_ctrl && addr_s == i[2:0] && code_s == `XPC_CODE_OFF_ONE)
					buf_on[i] <= 1'b0;
				else if (par_ctrl && addr_s == i[2:0] && code_s == `XPC_CODE_ON_ONE)
					buf_on[i] <= 1'b1;
				else if (par_ctrl && code_s == `XPC_CODE_OFF_ALL)
					buf_on[i] <= 1'b0;
				else if (par_ctrl && code_s == `XPC_CODE_ON_ALL)
					buf_on[i] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Switch outputs
	// ****************************************
	// Top bit set means the buffer input is grounded
	for (genvar g = 0; g < NUM_OUT; g++)
	begin : g_out
		assign conn_chan[3*g +: 3] = second_reg[FW-1-CW*g-1 -: 3];
		assign conn_gnd[g] = second_reg[FW-1-CW*g];
	end
endmodule // xpc_device

//--- tb/xpc_link_asserts.sv
// Purpose: Wire checks of the crosspoint control link
// Assumes: Host strobe half period of three clocks
// Notes: Sees the link pins only; switch outputs judged in bench
`timescale 1ns/1ps
module xpc_link_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Strobes and enables
	input wire logic wr,
	input wire logic latch,
	input wire logic ce,
	input wire logic ce_n,
	// Mode pins
	input wire logic interface_style_select,
	input wire logic edge_select,
	// Data pins
	input wire logic [2:0] buffer_select,
	input wire logic [3:0] host_code,
	input wire logic host_d1_oe_n,
	input wire logic shift_out,
	input wire logic shift_out_oe_n,
	input wire logic [3:0] command_code
);
	// Strobe rises since the last latch rise
	logic [5:0] frame_cnt;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// ****
	// Helper counter
	// ****
	// Cleared outside serial mode, so word bursts never count
	always_ff @(posedge sys_clk)
	begin
		if (!resetn || !interface_style_select || $rose(latch))
			frame_cnt <= 6'h00;
		else if ($rose(wr))
			frame_cnt <= frame_cnt + 6'h01;
	end

	// ****
	// Assertions
	// ****
	AST_WR_GATED: assert property (wr |-> ce && !ce_n)
		else $error("strobe high without both enables");
	AST_WR_WIDTH: assert property ($rose(wr) |-> wr[*3] ##1 !wr)
		else $error("strobe high time wrong");
	AST_LATCH_WIDTH: assert property ($fell(latch) |-> !latch[*3] ##1 latch)
		else $error("latch low time wrong");
	AST_DATA_HELD: assert property ($rose(wr) |-> $stable(buffer_select)
		&& $stable(command_code[0]))
		else $error("data moved at strobe rise");
	AST_FRAME_LEN: assert property (interface_style_select && $rose(latch) |-> frame_cnt == 6'h20)
		else $error("serial frame not 32 strobes");
	AST_SHIFT_DRIVE: assert property (interface_style_select[*5] |-> !shift_out_oe_n)
		else $error("serial output not driven");
	AST_SHIFT_RELEASE: assert property (!interface_style_select[*5] |-> shift_out_oe_n)
		else $error("serial output driven in parallel");
	AST_D1_RELEASE: assert property (interface_style_select |-> host_d1_oe_n)
		else $error("host drives shared bit in serial");
endmodule // xpc_link_asserts

//--- tb/tb_top.sv
// Purpose: Self-checking bench of host and device ends
// Assumes: Strobe half period shortened to three clocks
// Notes: Reference model of both ranks kept in bench arrays
`timescale 1ns/1ps
module tb_top;
	// Clock, reset, host controls
	logic sys_clk, resetn, cfg_serial, cfg_edge, req_valid, req_ready, done, err, d, e;
	xpc_pkg::xpc_req_t req_kind;
	logic [31:0] req_frame, f;
	logic [2:0] req_addr;
	logic [3:0] req_code;
	// Device outputs
	logic [23:0] conn_chan;
	logic [7:0] conn_gnd, buf_on;
	// Model: first rank, second rank, enables
	logic [3:0] fr [8];
	logic [3:0] sec [8];
	logic [7:0] on;
	int bad_count, checked, k;
	// Random word drawn before it is handed to the driver
	logic [2:0] a_r;
	logic [3:0] c_r;

	xpc_if link();
	xpc_host #(.HALF_CYC(3)) u_xpc_host (.sys_clk(sys_clk), .resetn(resetn), .link(link),
		.cfg_serial(cfg_serial), .cfg_edge(cfg_edge), .req_valid(req_valid),
		.req_ready(req_ready), .req_kind(req_kind), .req_frame(req_frame),
		.req_addr(req_addr), .req_code(req_code), .done(done), .err(err));
	xpc_device u_xpc_device (.sys_clk(sys_clk), .resetn(resetn), .link(link),
		.conn_chan(conn_chan), .conn_gnd(conn_gnd), .buf_on(buf_on));
	xpc_link_asserts u_xpc_link_asserts (.sys_clk(sys_clk), .resetn(resetn), .wr(link.wr),
		.latch(link.latch), .ce(link.ce), .ce_n(link.ce_n),
		.interface_style_select(link.interface_style_select), .edge_select(link.edge_select),
		.buffer_select(link.buffer_select), .host_code(link.host_code),
		.host_d1_oe_n(link.host_d1_oe_n), .shift_out(link.shift_out),
		.shift_out_oe_n(link.shift_out_oe_n), .command_code(link.command_code));

	// 250 MHz clock
	initial
	begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ****
	// Checks and expectations
	// ****
	task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
		checked++;
		if (g !== x)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask

	// Channel field is the low three bits of each second-rank entry
	function automatic logic [23:0] exp_chan();
		logic [23:0] r;
		for (int j = 0; j < 8; j++)
			r[3*j+:3] = sec[j][2:0];
		return r;
	endfunction

	// Ground flag is the top code bit
	function automatic logic [7:0] exp_gnd();
		logic [7:0] r;
		for (int j = 0; j < 8; j++)
			r[j] = sec[j][3];
		return r;
	endfunction

	task automatic cmp_all();
		chk("conn_chan", exp_chan(), conn_chan);
		chk("conn_gnd", {16'h0000, exp_gnd()}, {16'h0000, conn_gnd});
		chk("buf_on", {16'h0000, on}, {16'h0000, buf_on});
	endtask

	// Second-rank load; loaded 1001 and 1010 steer the enables
	task automatic m_latch();
		for (int j = 0; j < 8; j++)
		begin
			sec[j] = fr[j];
			if (fr[j] == 4'h9)
				on[j] = 1'h1;
			if (fr[j] == 4'hA)
				on[j] = 1'h0;
		end
	endtask

	// Parallel word effect; codes 1011 and above also copy the ranks
	task automatic m_word(input logic [2:0] a, input logic [3:0] c);
		if (c <= 4'h8)
			fr[a] = c;
		else if (c >= 4'hB)
			m_latch();
		case (c)
			4'hB: on[a] = 1'h0;
			4'hC: on[a] = 1'h1;
			4'hD: on = 8'h00;
			4'hE: on = 8'hFF;
			default: ;
		endcase
	endtask

	// ****
	// Request driver
	// ****
	// Holds valid for one take edge, then waits for done or err
	task automatic send(input xpc_pkg::xpc_req_t kd, input logic [31:0] fv,
		input logic [2:0] a, input logic [3:0] c);
		int n;
		@(posedge sys_clk);
		req_valid <= 1'h1;
		req_kind <= kd;
		req_frame <= fv;
		req_addr <= a;
		req_code <= c;
		@(posedge sys_clk);
		req_valid <= 1'h0;
		d = 1'h0;
		e = 1'h0;
		for (n = 0; n < 300 && !d && !e; n++)
		begin
			#1;
			d = (done === 1'h1);
			e = (err === 1'h1);
			if (!d && !e)
				@(posedge sys_clk);
		end
		// A request that never answers counts against the run
		if (!d && !e)
		begin
			bad_count++;
			$display("ERROR send_answer expected 1 seen 0");
		end
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic give_verdict();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		give_verdict();
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		resetn = 1'h0;
		cfg_serial = 1'h0;
		cfg_edge = 1'h1;
		req_valid = 1'h0;
		req_kind = xpc_pkg::XPC_REQ_LATCH;
		req_frame = 32'h0000_0000;
		req_addr = 3'h0;
		req_code = 4'h0;
		on = 8'h00;
		for (int j = 0; j < 8; j++)
		begin
			fr[j] = 4'h0;
			sec[j] = 4'h0;
		end
		k = $urandom(10);
		repeat (4) @(posedge sys_clk);
		resetn <= 1'h1;
		repeat (4) @(posedge sys_clk);
		cmp_all();
		// Word bursts in edge then level latch mode
		for (int m = 0; m < 2; m++)
		begin
			cfg_edge <= (m == 0);
			for (int n = 0; n < 10; n++)
			begin
				a_r = 3'($urandom_range(7, 0));
				c_r = 4'($urandom_range(8, 0));
				m_word(a_r, c_r);
				send(xpc_pkg::XPC_REQ_WORD, 32'h0000_0000, a_r, c_r);
				chk("word_done", 24'h00_0001, {23'h00_0000, d});
			end
			cmp_all();
			send(xpc_pkg::XPC_REQ_LATCH, 32'h0000_0000, 3'h0, 4'h0);
			m_latch();
			cmp_all();
		end
		// Every control code, random target
		for (int c = 9; c < 16; c++)
		begin
			a_r = 3'($urandom_range(7, 0));
			send(xpc_pkg::XPC_REQ_WORD, 32'h0000_0000, a_r, 4'(c));
			m_word(a_r, 4'(c));
			cmp_all();
		end
		send(xpc_pkg::XPC_REQ_FRAME, 32'h0000_0000, 3'h0, 4'h0);
		chk("frame_in_parallel_err", 24'h00_0001, {23'h00_0000, e});
		@(posedge sys_clk);
		cfg_serial <= 1'h1;
		// Serial frames in both latch modes, corner frame first
		for (int m = 0; m < 2; m++)
		begin
			cfg_edge <= (m == 0);
			for (int n = 0; n < 6; n++)
			begin
				f = 32'h9A89_7012;
				for (int j = 0; j < 8 && n > 0; j++)
					f[31-4*j-:4] = 4'($urandom_range(10, 0));
				send(xpc_pkg::XPC_REQ_FRAME, f, 3'h0, 4'h0);
				chk("frame_done", 24'h00_0001, {23'h00_0000, d});
				chk("shift_out", {23'h00_0000, f[31]},
					{23'h00_0000, link.command_code[1]});
				cmp_all();
				for (int j = 0; j < 8; j++)
					fr[j] = f[31-4*j-:4];
				send(xpc_pkg::XPC_REQ_LATCH, 32'h0000_0000, 3'h0, 4'h0);
				m_latch();
				cmp_all();
			end
		end
		send(xpc_pkg::XPC_REQ_FRAME, 32'h012B_4567, 3'h0, 4'h0);
		chk("bad_code_err", 24'h00_0001, {23'h00_0000, e});
		send(xpc_pkg::XPC_REQ_WORD, 32'h0000_0000, 3'h2, 4'h1);
		chk("word_in_serial_err", 24'h00_0001, {23'h00_0000, e});
		cmp_all();
		give_verdict();
	end
endmodule // tb_top
